// File: rtl/pucl_pkg.sv
// Shared constants and types of the power-up strap configuration loader.
`default_nettype none
package pucl_pkg;
	// Four-level strap codes from the analog level detector.
	localparam logic [1:0] LV4_GND    = 2'h0;
	localparam logic [1:0] LV4_THIRD  = 2'h1;
	localparam logic [1:0] LV4_TWO3RD = 2'h2;
	localparam logic [1:0] LV4_FULL   = 2'h3;
	// Three-level strap codes; code 3 is treated as mid level.
	localparam logic [1:0] LV3_GND    = 2'h0;
	localparam logic [1:0] LV3_MID    = 2'h1;
	localparam logic [1:0] LV3_FULL   = 2'h2;
	// Management register map.
	localparam logic [4:0] MEDIA_MODE_CONFIG_ADDR = 5'h1e;
	localparam logic [15:0] MEDIA_MODE_CONFIG_RST = 16'h0000;
	localparam logic [15:0] MEDIA_MODE_CONFIG_WMASK = 16'hcffe;
	localparam int B_NO_HD_ADV  = 15;
	localparam int B_AN_DIS     = 14;
	localparam int B_PASS_OFF   = 11;
	localparam int B_NO_FD_ADV  = 10;
	localparam int B_SINGLE_SPD = 9;
	localparam int B_SEL_10M    = 8;
	localparam int B_FO_PECL    = 7;
	localparam int B_LONG_WL    = 6;
	localparam int B_SHORT_FO   = 5;
	localparam int B_LOW_CUR    = 4;
	localparam int B_TP_PECL    = 3;
	localparam int B_SHORT_TP   = 2;
	localparam int B_SCR_DIS    = 1;
	// Timing at a 100 MHz clock.
	localparam int CLK_KHZ        = 100000;
	localparam int LATCH_DELAY_NS = 2000;
	localparam int LATCH_CYC      = (LATCH_DELAY_NS * CLK_KHZ + 999999) / 1000000;
	localparam int LIW_ON_MS      = 425;
	localparam int LIW_PERIOD_MS  = 3800;
	localparam int LIW_ON_CYC     = LIW_ON_MS * CLK_KHZ;
	localparam int LIW_PERIOD_CYC = LIW_PERIOD_MS * CLK_KHZ;
	localparam int MDIO_PRE_BITS  = 32;
	localparam logic [1:0] MDIO_OP_RD = 2'h2;
	localparam logic [1:0] MDIO_OP_WR = 2'h1;
	typedef enum logic [2:0] {
		PUCL_FORCED_10,
		PUCL_FORCED_100,
		PUCL_NT_HALF,
		PUCL_NT_FULL,
		PUCL_TRANSPARENT
	} pucl_mode_t;
endpackage
`default_nettype wire

// File: rtl/pucl_cfg_if.sv
// Decoded strap defaults passed from the decoder to the loader.
`default_nettype none
interface pucl_cfg_if;
	import pucl_pkg::*;
	logic [15:0] reg_dflt;
	logic [4:0]  phy_addr;
	logic        liw_en;
	pucl_mode_t  mode;
	modport dec (output reg_dflt, output phy_addr, output liw_en, output mode);
	modport ldr (input reg_dflt, input phy_addr, input liw_en, input mode);
endinterface
`default_nettype wire

// File: rtl/pucl_strap_dec.sv
// Combinational decode of strap level codes into register defaults.
`default_nettype none
module pucl_strap_dec
	import pucl_pkg::*;
(
	input  wire logic [1:0] addr_low,
	input  wire logic [1:0] addr_mid,
	input  wire logic [1:0] addr_high,
	input  wire logic [1:0] copper_sel,
	input  wire logic [1:0] fiber_sel,
	input  wire logic [1:0] duplex,
	input  wire logic [1:0] speed,
	pucl_cfg_if.dec         cfg
);
	function automatic logic [1:0] addr_pair(input logic [1:0] c);
		case (c)
			LV4_GND:    addr_pair = 2'h0;
			LV4_THIRD:  addr_pair = 2'h2;
			LV4_TWO3RD: addr_pair = 2'h3;
			default:    addr_pair = 2'h1;
		endcase
	endfunction

	// An open three-level pin floats to mid; an unknown code folds there too.
	function automatic logic [1:0] lv3(input logic [1:0] c);
		lv3 = (c == LV3_GND || c == LV3_FULL) ? c : LV3_MID;
	endfunction

	logic [1:0] dpx;
	logic [1:0] spd;
	logic [15:0] d;

	always_comb begin
		dpx = lv3(duplex);
		spd = lv3(speed);
		d = MEDIA_MODE_CONFIG_RST;
		d[B_TP_PECL]    = (copper_sel == LV4_THIRD);
		d[B_SHORT_TP]   = (copper_sel == LV4_TWO3RD) || (copper_sel == LV4_FULL);
		d[B_LOW_CUR]    = (copper_sel == LV4_TWO3RD);
		d[B_FO_PECL]    = (fiber_sel == LV4_THIRD);
		d[B_SHORT_FO]   = (fiber_sel == LV4_FULL);
		d[B_LONG_WL]    = (fiber_sel == LV4_TWO3RD);
		d[B_PASS_OFF]   = (dpx != LV3_MID);
		d[B_NO_FD_ADV]  = (dpx == LV3_GND);
		d[B_NO_HD_ADV]  = 1'b0;
		d[B_AN_DIS]     = (spd != LV3_MID);
		d[B_SINGLE_SPD] = (spd != LV3_MID);
		d[B_SEL_10M]    = (spd == LV3_GND);
		d[B_SCR_DIS]    = 1'b0;
		cfg.reg_dflt = d;
		cfg.phy_addr = {addr_high[1], addr_pair(addr_mid), addr_pair(addr_low)};
		cfg.liw_en = (addr_high == LV4_THIRD) || (addr_high == LV4_TWO3RD);
		// Speed and duplex straps are weighed together for the start-up mode.
		if (spd == LV3_GND) begin
			cfg.mode = PUCL_FORCED_10;
		end else if (spd == LV3_FULL) begin
			cfg.mode = PUCL_FORCED_100;
		end else if (dpx == LV3_GND) begin
			cfg.mode = PUCL_NT_HALF;
		end else if (dpx == LV3_FULL) begin
			cfg.mode = PUCL_NT_FULL;
		end else begin
			cfg.mode = PUCL_TRANSPARENT;
		end
	end
endmodule
`default_nettype wire

// File: rtl/pucl_mdio.sv
// Serial management slave serving the media mode register.
`default_nettype none
module pucl_mdio
	import pucl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        mdc_s,
	input  wire logic        mdio_s,
	input  wire logic        en,
	input  wire logic [4:0]  phy_addr,
	input  wire logic [15:0] rd_data,
	output logic             mdio_o,
	output logic             mdio_oe,
	output logic             wr_en,
	output logic [15:0]      wr_data
);
	typedef enum logic [2:0] {M_PRE, M_ST, M_HDR, M_TA, M_DAT} pucl_mst_t;

	pucl_mst_t   st_r, st_nxt;
	logic [5:0]  pre_r, pre_nxt;
	logic [4:0]  cnt_r, cnt_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic [1:0]  op_r, op_nxt;
	logic        hit_r, hit_nxt;
	logic        rd_r, rd_nxt;
	logic [16:0] osh_r, osh_nxt;
	logic [4:0]  fcnt_r, fcnt_nxt;
	logic        o_nxt, oe_nxt, we_nxt;
	logic [15:0] wd_nxt;
	logic        mdc_d_r;
	logic        rise, fall;

	assign rise = mdc_s & ~mdc_d_r;
	assign fall = ~mdc_s & mdc_d_r;

	always_comb begin
		st_nxt = st_r;
		pre_nxt = pre_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		op_nxt = op_r;
		hit_nxt = hit_r;
		rd_nxt = rd_r;
		osh_nxt = osh_r;
		fcnt_nxt = fcnt_r;
		o_nxt = mdio_o;
		oe_nxt = mdio_oe;
		we_nxt = 1'b0;
		wd_nxt = wr_data;
		if (rise) begin
			case (st_r)
				M_PRE: begin
					if (mdio_s) begin
						pre_nxt = (pre_r == 6'(MDIO_PRE_BITS)) ? pre_r : pre_r + 6'h01;
					end else if (pre_r == 6'(MDIO_PRE_BITS)) begin
						st_nxt = M_ST;
					end else begin
						pre_nxt = 6'h00;
					end
				end
				M_ST: begin
					st_nxt = mdio_s ? M_HDR : M_PRE;
					pre_nxt = 6'h00;
					cnt_nxt = 5'h00;
				end
				M_HDR: begin
					sh_nxt = {sh_r[14:0], mdio_s};
					cnt_nxt = cnt_r + 5'h01;
					if (cnt_r == 5'd11) begin
						// Frames for another address are followed silently.
						op_nxt = sh_r[10:9];
						hit_nxt = en && (sh_r[8:4] == phy_addr)
							&& (sh_r[10:9] == MDIO_OP_RD || sh_r[10:9] == MDIO_OP_WR);
						st_nxt = M_TA;
						cnt_nxt = 5'h00;
					end
				end
				M_TA: begin
					cnt_nxt = cnt_r + 5'h01;
					// The register field is only whole now; data shifts it out later.
					if (cnt_r == 5'h00 && op_r == MDIO_OP_WR) begin
						hit_nxt = hit_r && (sh_r[4:0] == MEDIA_MODE_CONFIG_ADDR);
					end
					if (cnt_r == 5'h00 && hit_r && op_r == MDIO_OP_RD) begin
						rd_nxt = 1'b1;
						fcnt_nxt = 5'h00;
						osh_nxt = {1'b0, (sh_r[4:0] == MEDIA_MODE_CONFIG_ADDR) ? rd_data : 16'h0000};
					end
					if (cnt_r == 5'h01) begin
						st_nxt = M_DAT;
						cnt_nxt = 5'h00;
					end
				end
				M_DAT: begin
					sh_nxt = {sh_r[14:0], mdio_s};
					cnt_nxt = cnt_r + 5'h01;
					if (cnt_r == 5'd15) begin
						st_nxt = M_PRE;
						we_nxt = hit_r && op_r == MDIO_OP_WR;
						wd_nxt = {sh_r[14:0], mdio_s};
					end
				end
				default: st_nxt = M_PRE;
			endcase
		end
		// Read data leaves on falling edges so the station samples it on rising ones.
		if (fall && rd_r) begin
			if (fcnt_r == 5'd17) begin
				rd_nxt = 1'b0;
				oe_nxt = 1'b0;
				o_nxt = 1'b0;
			end else begin
				oe_nxt = 1'b1;
				o_nxt = osh_r[16];
				osh_nxt = {osh_r[15:0], 1'b0};
				fcnt_nxt = fcnt_r + 5'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= M_PRE;
			pre_r <= 6'h00;
			cnt_r <= 5'h00;
			sh_r <= 16'h0000;
			op_r <= 2'h0;
			hit_r <= 1'b0;
			rd_r <= 1'b0;
			osh_r <= 17'h00000;
			fcnt_r <= 5'h00;
			mdio_o <= 1'b0;
			mdio_oe <= 1'b0;
			wr_en <= 1'b0;
			wr_data <= 16'h0000;
			mdc_d_r <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			op_r <= op_nxt;
			hit_r <= hit_nxt;
			rd_r <= rd_nxt;
			osh_r <= osh_nxt;
			fcnt_r <= fcnt_nxt;
			mdio_o <= o_nxt;
			mdio_oe <= oe_nxt;
			wr_en <= we_nxt;
			wr_data <= wd_nxt;
			mdc_d_r <= mdc_s;
		end
	end
endmodule
`default_nettype wire

// File: rtl/pucl_top.sv
// Power-up strap configuration loader: strap capture, media register, warning timer.
`default_nettype none
module pucl_top
	import pucl_pkg::*;
#(
	parameter int unsigned LATCH_CYC_P      = LATCH_CYC,
	parameter int unsigned LIW_ON_CYC_P     = LIW_ON_CYC,
	parameter int unsigned LIW_PERIOD_CYC_P = LIW_PERIOD_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic [1:0] phy_addr_low_strap,
	input  wire logic [1:0] phy_addr_mid_strap,
	input  wire logic [1:0] phy_addr_high_warn_strap,
	input  wire logic [1:0] copper_if_select_strap,
	input  wire logic [1:0] fiber_if_select_strap,
	input  wire logic [1:0] duplex_strap,
	input  wire logic [1:0] speed_strap,
	input  wire logic       mdc,
	input  wire logic       mdio_i,
	output logic            mdio_o,
	output logic            mdio_oe,
	input  wire logic       copper_link_up,
	input  wire logic       fiber_link_up,
	output logic            cfg_done,
	output logic [4:0]      phy_address,
	output logic            link_integrity_warning,
	output logic [15:0]     media_mode_config,
	output logic [2:0]      op_mode,
	output logic            scrambler_en,
	output logic            rx_eq_bypass,
	output logic            sd_thresh_raise,
	output logic            copper_tx_blank,
	output logic            fiber_tx_blank
);
	localparam int NSTRAP = 7;

	// Pin synchronisers: every strap and the management pins pass two flops.
	logic [2*NSTRAP-1:0] strap_raw;
	logic [2*NSTRAP-1:0] strap_m_r;
	logic [2*NSTRAP-1:0] strap_s_r;
	logic [1:0]          mgmt_m_r;
	logic [1:0]          mgmt_s_r;

	assign strap_raw = {speed_strap, duplex_strap, fiber_if_select_strap,
		copper_if_select_strap, phy_addr_high_warn_strap, phy_addr_mid_strap,
		phy_addr_low_strap};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_m_r <= '0;
			strap_s_r <= '0;
			mgmt_m_r <= 2'h0;
			mgmt_s_r <= 2'h0;
		end else if (ce) begin
			strap_m_r <= strap_raw;
			strap_s_r <= strap_m_r;
			mgmt_m_r <= {mdc, mdio_i};
			mgmt_s_r <= mgmt_m_r;
		end
	end

	// Strap decoding.
	pucl_cfg_if cfg ();
	logic [1:0] code [NSTRAP];

	genvar gi;
	generate
		for (gi = 0; gi < NSTRAP; gi++) begin : g_code
			assign code[gi] = strap_s_r[2*gi +: 2];
		end
	endgenerate

	pucl_strap_dec u_dec (
		.addr_low   (code[0]),
		.addr_mid   (code[1]),
		.addr_high  (code[2]),
		.copper_sel (code[3]),
		.fiber_sel  (code[4]),
		.duplex     (code[5]),
		.speed      (code[6]),
		.cfg        (cfg.dec)
	);

	// Capture timer: the straps are sampled once, the delay after reset release
	// letting board pull-ups settle, and never again until the next reset.
	localparam int LW = $clog2(LATCH_CYC_P + 1);
	logic [LW-1:0] lcnt_r, lcnt_nxt;
	logic          done_nxt;
	logic          load;

	assign load = !cfg_done && (lcnt_r == LW'(LATCH_CYC_P));

	always_comb begin
		lcnt_nxt = lcnt_r;
		done_nxt = cfg_done;
		if (load) begin
			done_nxt = 1'b1;
		end else if (!cfg_done) begin
			lcnt_nxt = lcnt_r + LW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lcnt_r <= '0;
			cfg_done <= 1'b0;
		end else if (ce) begin
			lcnt_r <= lcnt_nxt;
			cfg_done <= done_nxt;
		end
	end

	// Held strap results; all codes are taken on the single load cycle.
	logic [4:0]  addr_nxt;
	logic        liw_nxt;
	logic [2:0]  mode_nxt;
	logic [15:0] reg_nxt;
	logic        wr_en;
	logic [15:0] wr_data;

	always_comb begin
		addr_nxt = phy_address;
		liw_nxt = link_integrity_warning;
		mode_nxt = op_mode;
		reg_nxt = media_mode_config;
		if (load) begin
			addr_nxt = cfg.phy_addr;
			liw_nxt = cfg.liw_en;
			mode_nxt = 3'(cfg.mode);
			reg_nxt = cfg.reg_dflt;
		end
		// A write landing on the load cycle is the later intent and wins.
		if (wr_en) begin
			reg_nxt = wr_data & MEDIA_MODE_CONFIG_WMASK;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phy_address <= 5'h00;
			link_integrity_warning <= 1'b0;
			op_mode <= 3'h0;
			media_mode_config <= MEDIA_MODE_CONFIG_RST;
		end else if (ce) begin
			phy_address <= addr_nxt;
			link_integrity_warning <= liw_nxt;
			op_mode <= mode_nxt;
			media_mode_config <= reg_nxt;
		end
	end

	// Management slave; it stays deaf until its address is known.
	pucl_mdio u_mdio (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.mdc_s    (mgmt_s_r[1]),
		.mdio_s   (mgmt_s_r[0]),
		.en       (cfg_done),
		.phy_addr (phy_address),
		.rd_data  (media_mode_config),
		.mdio_o   (mdio_o),
		.mdio_oe  (mdio_oe),
		.wr_en    (wr_en),
		.wr_data  (wr_data)
	);

	// Media controls follow the live register, so management retuning takes effect.
	logic tp_sel;
	logic qu_sel;
	logic scr_nxt;
	logic eqb_nxt;
	logic sdr_nxt;

	assign tp_sel = ~media_mode_config[B_TP_PECL];
	assign qu_sel = ~media_mode_config[B_FO_PECL];

	always_comb begin
		scr_nxt = cfg_done && tp_sel && !media_mode_config[B_SCR_DIS];
		// Ten-meter reach is short reach at standard drive current.
		eqb_nxt = cfg_done && tp_sel && media_mode_config[B_SHORT_TP]
			&& !media_mode_config[B_LOW_CUR];
		sdr_nxt = cfg_done && qu_sel && media_mode_config[B_SHORT_FO];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scrambler_en <= 1'b0;
			rx_eq_bypass <= 1'b0;
			sd_thresh_raise <= 1'b0;
		end else if (ce) begin
			scrambler_en <= scr_nxt;
			rx_eq_bypass <= eqb_nxt;
			sd_thresh_raise <= sdr_nxt;
		end
	end

	// Link warning timer: a period counter, cleared while the warning is inactive, whose first part is the blank window.
	logic [31:0] pcnt_r, pcnt_nxt;
	logic        liw_act;
	logic        win;
	logic        cu_blank_nxt;
	logic        fo_blank_nxt;

	assign liw_act = cfg_done && link_integrity_warning
		&& media_mode_config[B_SINGLE_SPD];
	assign win = (pcnt_r < LIW_ON_CYC_P);

	always_comb begin
		pcnt_nxt = 32'h00000000;
		if (liw_act) begin
			pcnt_nxt = (pcnt_r == LIW_PERIOD_CYC_P - 1) ? 32'h00000000 : pcnt_r + 32'h00000001;
		end
		// With both links down there is nothing to pass, so both stay off.
		cu_blank_nxt = liw_act && !copper_link_up && (win || !fiber_link_up);
		fo_blank_nxt = liw_act && !fiber_link_up && (win || !copper_link_up);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pcnt_r <= 32'h00000000;
			copper_tx_blank <= 1'b0;
			fiber_tx_blank <= 1'b0;
		end else if (ce) begin
			pcnt_r <= pcnt_nxt;
			copper_tx_blank <= cu_blank_nxt;
			fiber_tx_blank <= fo_blank_nxt;
		end
	end
endmodule
`default_nettype wire

// File: tb/pucl_assertions.sv
// Port-level checker for the strap configuration loader.
`default_nettype none
module pucl_assertions
	import pucl_pkg::*;
#(
	parameter int unsigned LATCH_CYC_P = 4
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        ce,
	input wire logic [1:0]  phy_addr_low_strap,
	input wire logic [1:0]  phy_addr_mid_strap,
	input wire logic [1:0]  phy_addr_high_warn_strap,
	input wire logic [1:0]  copper_if_select_strap,
	input wire logic [1:0]  fiber_if_select_strap,
	input wire logic [1:0]  duplex_strap,
	input wire logic        copper_link_up,
	input wire logic        mdio_oe,
	input wire logic        cfg_done,
	input wire logic [4:0]  phy_address,
	input wire logic        link_integrity_warning,
	input wire logic [15:0] media_mode_config,
	input wire logic        scrambler_en,
	input wire logic        rx_eq_bypass,
	input wire logic        sd_thresh_raise,
	input wire logic        copper_tx_blank
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] wait_r;
	logic [7:0] wait_nxt;
	function automatic logic [1:0] amap(input logic [1:0] c);
		return {^c, c[1]};
	endfunction
	// Counts edges from reset release until the load, so the latency is pinned down.
	always_comb begin
		wait_nxt = cfg_done ? wait_r : wait_r + 8'h01;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_r <= 8'h00;
		end else if (ce) begin
			wait_r <= wait_nxt;
		end
	end
	property p_done_hold; cfg_done |=> cfg_done; endproperty
	a_done_hold: assert property (p_done_hold) else $error("load flag dropped");
	property p_done_time;
		$rose(cfg_done) |-> wait_r >= LATCH_CYC_P + 1 && wait_r <= LATCH_CYC_P + 2;
	endproperty
	a_done_time: assert property (p_done_time) else $error("load late or early");
	property p_stable; cfg_done |=> $stable({phy_address, link_integrity_warning}); endproperty
	a_stable: assert property (p_stable) else $error("latched value moved");
	property p_addr;
		$rose(cfg_done) |-> phy_address[3:0] ==
			{amap(phy_addr_mid_strap), amap(phy_addr_low_strap)};
	endproperty
	a_addr: assert property (p_addr) else $error("address decode");
	property p_hi;
		$rose(cfg_done) |-> {phy_address[4], link_integrity_warning} ==
			{phy_addr_high_warn_strap[1], ^phy_addr_high_warn_strap};
	endproperty
	a_hi: assert property (p_hi) else $error("upper strap decode");
	property p_cu;
		$rose(cfg_done) |-> media_mode_config[4:2] == {copper_if_select_strap == LV4_TWO3RD,
			copper_if_select_strap == LV4_THIRD, copper_if_select_strap[1]};
	endproperty
	a_cu: assert property (p_cu) else $error("copper defaults");
	property p_fo;
		$rose(cfg_done) |-> media_mode_config[7:5] == {fiber_if_select_strap == LV4_THIRD,
			fiber_if_select_strap == LV4_TWO3RD, fiber_if_select_strap == LV4_FULL};
	endproperty
	a_fo: assert property (p_fo) else $error("fiber defaults");
	property p_dup;
		$rose(cfg_done) |-> {media_mode_config[15], media_mode_config[11:10]} == {1'b0,
			duplex_strap == LV3_GND || duplex_strap == LV3_FULL, duplex_strap == LV3_GND};
	endproperty
	a_dup: assert property (p_dup) else $error("duplex defaults");
	property p_scr;
		$past(cfg_done) && !$past(media_mode_config[B_TP_PECL])
			|-> scrambler_en == !$past(media_mode_config[B_SCR_DIS]);
	endproperty
	a_scr: assert property (p_scr) else $error("scrambler enable");
	property p_eq;
		$past(cfg_done) |-> rx_eq_bypass ==
			($past(media_mode_config[B_SHORT_TP]) && !$past(media_mode_config[B_LOW_CUR])
			&& !$past(media_mode_config[B_TP_PECL]));
	endproperty
	a_eq: assert property (p_eq) else $error("equalizer bypass");
	property p_sd;
		$past(cfg_done) |-> sd_thresh_raise ==
			($past(media_mode_config[B_SHORT_FO]) && !$past(media_mode_config[B_FO_PECL]));
	endproperty
	a_sd: assert property (p_sd) else $error("detect threshold");
	property p_blank;
		copper_tx_blank |-> link_integrity_warning
			&& $past(media_mode_config[B_SINGLE_SPD]) && !$past(copper_link_up);
	endproperty
	a_blank: assert property (p_blank) else $error("blank without cause");
	property p_quiet; !cfg_done |-> !mdio_oe; endproperty
	a_quiet: assert property (p_quiet) else $error("drive before load");
	c_load: cover property ($rose(cfg_done));
	c_blank: cover property (copper_tx_blank);
	c_read: cover property ($rose(mdio_oe));
endmodule
bind pucl_top pucl_assertions #(.LATCH_CYC_P(LATCH_CYC_P)) u_chk (
	.clk, .rst_n, .ce, .phy_addr_low_strap, .phy_addr_mid_strap, .phy_addr_high_warn_strap,
	.copper_if_select_strap, .fiber_if_select_strap, .duplex_strap, .copper_link_up,
	.mdio_oe, .cfg_done, .phy_address, .link_integrity_warning, .media_mode_config,
	.scrambler_en, .rx_eq_bypass, .sd_thresh_raise, .copper_tx_blank);
`default_nettype wire

// File: tb/pucl_mgmt_model.sv
// Management station with the board pull-up on the shared data line.
`default_nettype none
module pucl_mgmt_model
	import pucl_pkg::*;
(
	input  wire logic clk,
	input  wire logic mdio_o,
	input  wire logic mdio_oe,
	output var logic  mdc,
	output logic      mdio_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic drv_oe;
	logic drv_val;
	// A released line floats up to one, so stale data never reads back.
	assign mdio_i = mdio_oe ? mdio_o : (drv_oe ? drv_val : 1'b1);
	initial begin
		mdc = 1'b0;
		drv_oe = 1'b0;
		drv_val = 1'b0;
	end
	// Long phases leave room for the loader's input synchronisers.
	task automatic bit_cyc(input logic d, input logic drive, output logic s);
		mdc = 1'b0;
		drv_oe = drive;
		drv_val = d;
		repeat (8) @(posedge clk);
		#1;
		s = mdio_i;
		mdc = 1'b1;
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hdr;
		logic        s;
		logic        wr;
		hdr = {32'hffffffff, 2'h1, op, phy, rg};
		wr = (op == MDIO_OP_WR);
		rd = 16'h0000;
		for (int i = 45; i >= 0; i--) begin
			bit_cyc(hdr[i], 1'b1, s);
		end
		bit_cyc(1'b1, wr, s);
		bit_cyc(1'b0, wr, s);
		for (int i = 15; i >= 0; i--) begin
			bit_cyc(wd[i], wr, s);
			rd[i] = s;
		end
		bit_cyc(1'b1, 1'b0, s);
		// Park the clock low so a later reset release sees no false rising edge.
		mdc = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the strap configuration loader.
`default_nettype none
module tb import pucl_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst_n, ce, mdc, mdio_i, mdio_o, mdio_oe, copper_link_up, fiber_link_up;
	logic [1:0]  phy_addr_low_strap, phy_addr_mid_strap, phy_addr_high_warn_strap;
	logic [1:0]  copper_if_select_strap, fiber_if_select_strap, duplex_strap, speed_strap;
	logic        cfg_done, link_integrity_warning, scrambler_en, rx_eq_bypass;
	logic        sd_thresh_raise, copper_tx_blank, fiber_tx_blank;
	logic [4:0]  phy_address;
	logic [15:0] media_mode_config;
	logic [15:0] rd;
	logic [2:0]  op_mode;
	int          fails = 0;
	int          compares = 0;
	pucl_top #(.LATCH_CYC_P(4), .LIW_ON_CYC_P(5), .LIW_PERIOD_CYC_P(20)) DUT (
		.clk, .rst_n, .ce, .phy_addr_low_strap, .phy_addr_mid_strap,
		.phy_addr_high_warn_strap, .copper_if_select_strap, .fiber_if_select_strap,
		.duplex_strap, .speed_strap, .mdc, .mdio_i, .mdio_o, .mdio_oe, .copper_link_up,
		.fiber_link_up, .cfg_done, .phy_address, .link_integrity_warning,
		.media_mode_config, .op_mode, .scrambler_en, .rx_eq_bypass, .sd_thresh_raise,
		.copper_tx_blank, .fiber_tx_blank);
	pucl_mgmt_model u_mgmt (.clk, .mdio_o, .mdio_oe, .mdc, .mdio_i);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	function automatic logic [15:0] exp_reg(input logic [1:0] cu, fi, du, sp);
		logic [15:0] r;
		r = 16'h0000;
		r[B_NO_FD_ADV] = (du == LV3_GND);
		r[B_PASS_OFF] = (du == LV3_GND) || (du == LV3_FULL);
		r[B_AN_DIS] = (sp == LV3_GND) || (sp == LV3_FULL);
		r[B_SINGLE_SPD] = r[B_AN_DIS];
		r[B_SEL_10M] = (sp == LV3_GND);
		r[B_FO_PECL] = (fi == LV4_THIRD);
		r[B_LONG_WL] = (fi == LV4_TWO3RD);
		r[B_SHORT_FO] = (fi == LV4_FULL);
		r[B_LOW_CUR] = (cu == LV4_TWO3RD);
		r[B_TP_PECL] = (cu == LV4_THIRD);
		r[B_SHORT_TP] = cu[1];
		return r;
	endfunction
	function automatic logic [2:0] exp_mode(input logic [1:0] du, sp);
		if (sp == LV3_GND) return PUCL_FORCED_10;
		if (sp == LV3_FULL) return PUCL_FORCED_100;
		if (du == LV3_GND) return PUCL_NT_HALF;
		if (du == LV3_FULL) return PUCL_NT_FULL;
		return PUCL_TRANSPARENT;
	endfunction
	task automatic straps(input logic [1:0] lo, mi, hi, cu, fi, du, sp);
		{phy_addr_low_strap, phy_addr_mid_strap, phy_addr_high_warn_strap} = {lo, mi, hi};
		{copper_if_select_strap, fiber_if_select_strap} = {cu, fi};
		{duplex_strap, speed_strap} = {du, sp};
	endtask
	task automatic load(input logic [1:0] lo, mi, hi, cu, fi, du, sp);
		int n;
		rst_n = 1'b0;
		straps(lo, mi, hi, cu, fi, du, sp);
		wt(5);
		rst_n = 1'b1;
		// With the enable low the capture timer must not advance at all.
		ce = 1'b0;
		wt(10);
		chk(cfg_done, 1'b0);
		ce = 1'b1;
		n = 0;
		while (cfg_done !== 1'b1 && n < 20) begin
			wt(1);
			n++;
		end
		chk(cfg_done, 1'b1);
		wt(2);
	endtask
	task automatic t_decode();
		logic [1:0] k2, mi, hi, fi, sp;
		for (int k = 0; k < 8; k++) begin
			k2 = k[1:0];
			{mi, hi, fi} = {k2 + 2'h1, k2 + 2'h2, k2 + 2'h3};
			sp = (k < 4) ? k2 : LV3_MID;
			load(k2, mi, hi, k2, fi, k2, sp);
			// Moving every strap after the load must change nothing.
			straps(~k2, ~mi, ~hi, ~k2, ~fi, ~k2, ~sp);
			wt(3);
			chk(phy_address, {hi[1], ^mi, mi[1], ^k2, k2[1]});
			chk(link_integrity_warning, ^hi);
			chk(media_mode_config, exp_reg(k2, fi, k2, sp));
			chk(op_mode, exp_mode(k2, sp));
			chk(scrambler_en, k2 != LV4_THIRD);
			chk(rx_eq_bypass, k2 == LV4_FULL);
			chk(sd_thresh_raise, fi == LV4_FULL);
		end
	endtask
	task automatic t_mgmt();
		load(2'h2, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0);
		u_mgmt.xfer(MDIO_OP_RD, 5'h0b, MEDIA_MODE_CONFIG_ADDR, 16'h0000, rd);
		chk(rd, exp_reg(2'h2, 2'h2, 2'h0, 2'h0));
		u_mgmt.xfer(MDIO_OP_WR, 5'h0b, MEDIA_MODE_CONFIG_ADDR, 16'hffff, rd);
		chk(media_mode_config, MEDIA_MODE_CONFIG_WMASK);
		chk(scrambler_en, 1'b0);
		u_mgmt.xfer(MDIO_OP_RD, 5'h0b, MEDIA_MODE_CONFIG_ADDR, 16'h0000, rd);
		chk(rd, MEDIA_MODE_CONFIG_WMASK);
		u_mgmt.xfer(MDIO_OP_RD, 5'h0b, 5'h00, 16'h0000, rd);
		chk(rd, 16'h0000);
		u_mgmt.xfer(MDIO_OP_RD, 5'h0a, MEDIA_MODE_CONFIG_ADDR, 16'h0000, rd);
		chk(rd, 16'hffff);
		u_mgmt.xfer(MDIO_OP_WR, 5'h0a, MEDIA_MODE_CONFIG_ADDR, 16'h0000, rd);
		chk(media_mode_config, MEDIA_MODE_CONFIG_WMASK);
		u_mgmt.xfer(MDIO_OP_WR, 5'h0b, MEDIA_MODE_CONFIG_ADDR, 16'h0000, rd);
		chk(scrambler_en, 1'b1);
	endtask
	task automatic blanks(input logic [15:0] ec, input logic [15:0] ef);
		int nc, nf;
		{nc, nf} = {32'd0, 32'd0};
		for (int i = 0; i < 40; i++) begin
			wt(1);
			nc += (copper_tx_blank === 1'b1);
			nf += (fiber_tx_blank === 1'b1);
		end
		chk(nc[15:0], ec);
		chk(nf[15:0], ef);
	endtask
	task automatic t_liw();
		load(2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0);
		copper_link_up = 1'b0;
		wt(25);
		blanks(16'h000a, 16'h0000);
		fiber_link_up = 1'b0;
		wt(3);
		blanks(16'h0028, 16'h0028);
		u_mgmt.xfer(MDIO_OP_WR, 5'h00, MEDIA_MODE_CONFIG_ADDR,
			exp_reg(2'h0, 2'h0, 2'h1, 2'h0) & ~16'h0200, rd);
		wt(3);
		blanks(16'h0000, 16'h0000);
		{copper_link_up, fiber_link_up} = 2'h3;
	endtask
	task automatic test_done();
		if (fails == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		test_done();
	end
	initial begin
		ce = 1'b1;
		{copper_link_up, fiber_link_up} = 2'h3;
		t_decode();
		t_mgmt();
		t_liw();
		test_done();
	end
endmodule
`default_nettype wire
